/* File: bench/capture_model.sv */
`timescale 1ns/1ps

module capture_model (
  input wire logic pclk,
  input wire logic [11:0] word,
  input wire logic flag,
  input wire logic word_oe,
  input wire logic flag_oe,
  output conv_port_pkg::result_t captured_r
);
  import conv_port_pkg::*;

  // Holds its last capture while the pins float
  always @(posedge pclk) begin
    if (word_oe && flag_oe) begin
      captured_r <= {flag, word};
    end
  end
endmodule : capture_model

/* File: bench/test_adc_output_port_control.sv */
`timescale 1ns/1ps
`include "conv_port_map.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end

module test_adc_output_port_control;
  import conv_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_clk = 1'b0;
  logic signed [13:0] analog_level = 14'sh0000;
  logic [11:0] conversion_result;
  logic conversion_result_oe;
  logic range_flag;
  logic range_flag_oe;
  power_state_t power_state;
  logic irq;
  result_t captured_r;
  logic [31:0] rd_data;
  logic rd_err;
  logic [31:0] cnt;
  logic [11:0] word_pin;
  logic flag_pin;
  result_t held;
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'h6d252482;
  logic signed [13:0] corner [4] = '{14'sh07FF, 14'sh0800, 14'sh3800, 14'sh37FF};

  conv_port_ctrl i_conv_port_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_clk(sample_clk),
    .analog_level(analog_level), .conversion_result(conversion_result),
    .conversion_result_oe(conversion_result_oe), .range_flag(range_flag),
    .range_flag_oe(range_flag_oe), .power_state(power_state), .irq(irq));

  // Released pins show the inverse, so a stray capture is caught
  assign word_pin = conversion_result_oe ? conversion_result : ~conversion_result;
  assign flag_pin = range_flag_oe ? range_flag : ~range_flag;

  capture_model i_capture_model (.pclk(pclk), .word(word_pin), .flag(flag_pin),
    .word_oe(conversion_result_oe), .flag_oe(range_flag_oe), .captured_r(captured_r));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  function automatic result_t exp_result(logic signed [13:0] lv, logic [1:0] fs);
    logic signed [13:0] c;
    c = (lv > 14'sh07FF) ? 14'sh07FF : (lv < 14'sh3800) ? 14'sh3800 : lv;
    exp_result.range_flag = (lv > 14'sh07FF) || (lv < 14'sh3800);
    // Offset binary is the two's complement word with its top bit flipped
    exp_result.code = fs[1] ? c[11:0] : c[11:0] ^ 12'h800;
  endfunction : exp_result

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) errors++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic sample(input int n, input logic [1:0] fs, input logic chk);
    logic signed [13:0] lv;
    result_t ex [16];
    for (int i = 0; i < n; i++) begin
      lv = (i < 4) ? corner[(i + fs) % 4] : 14'($random(seed) % 2600);
      ex[i] = exp_result(lv, fs);
      @(posedge pclk);
      analog_level <= lv;
      repeat (3) @(posedge pclk);
      sample_clk <= 1'b1;
      // Six high cycles cover sync, detect and capture
      repeat (6) @(posedge pclk);
      sample_clk <= 1'b0;
      @(negedge pclk);
      if (chk && i >= 5) `CHK(captured_r, ex[i - 5])
    end
  endtask : sample

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK(power_state, ST_OUTPUT_OFF)
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd_data, 32'h0000_0002)
    apb(1'b0, `REG_INT_MASK, 32'h0);
    `CHK(rd_data, 32'h0000_0000)
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `REG_CTRL, 32'(m));
      apb(1'b0, `REG_SAMPLE_COUNT, 32'h0);
      cnt = rd_data;
      sample(6, 2'h0, 1'b0);
      `CHK(power_state, power_state_t'({m[0], m[1]}))
      `CHK(conversion_result_oe, m == 0)
      `CHK(range_flag_oe, m == 0)
      apb(1'b0, `REG_SAMPLE_COUNT, 32'h0);
      `CHK(rd_data[15:0], cnt[15:0] + (m[0] ? 16'h0 : 16'h6))
      if (m == 0) held = captured_r;
      else `CHK(captured_r, held)
    end
    for (int fs = 0; fs < 4; fs++) begin
      apb(1'b1, `REG_CTRL, 32'(fs << 2));
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(rd_data[4:0], {1'b1, fs[1], fs[0] ^ fs[1], 2'b00})
      sample(9, 2'(fs), 1'b1);
    end
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_INT_STATUS, 32'h7);
    apb(1'b1, `REG_INT_MASK, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    sample(1, 2'h0, 1'b0);
    `CHK(irq, 1'b1)
    apb(1'b1, `REG_INT_MASK, 32'h0);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, `REG_INT_MASK, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `REG_INT_STATUS, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b0, 12'h040, 32'h0);
    `CHK(rd_err, 1'b1)
    `CHK(rd_data, 32'h0000_0000)
    print_verdict();
  end
endmodule : test_adc_output_port_control

/* File: hdl/conv_port_ctrl.sv */
`timescale 1ns/1ps
`include "conv_port_map.svh"

module conv_port_ctrl #(
  parameter int DATA_W = `CONV_WIDTH,
  parameter int LATENCY = `PIPE_LATENCY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_clk,
  input wire logic signed [`LEVEL_WIDTH-1:0] analog_level,
  output logic [DATA_W-1:0] conversion_result,
  output logic conversion_result_oe,
  output logic range_flag,
  output logic range_flag_oe,
  output conv_port_pkg::power_state_t power_state,
  output logic irq
);
  import conv_port_pkg::*;

  initial begin
    if (DATA_W != `CONV_WIDTH) begin
      $error("DATA_W must equal the result struct width");
    end
    if (LATENCY < 2 || LATENCY > 8) begin
      $error("LATENCY must lie between 2 and 8");
    end
  end

  localparam logic signed [`LEVEL_WIDTH-1:0] LEVEL_MAX = 14'sh07FF;
  localparam logic signed [`LEVEL_WIDTH-1:0] LEVEL_MIN = -14'sh0800;
  // Reset control word, split into its fields at reset
  localparam logic [3:0] CTRL_RST = `CTRL_RESET;

  // Pin synchronisers; stage 1 feeds stage 2 only
  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_s3_r;
  logic signed [`LEVEL_WIDTH-1:0] level_s1_r;
  logic signed [`LEVEL_WIDTH-1:0] level_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
    end else begin
      clk_s1_r <= sample_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end

  // Level passes the same two stages as the clock edge, so it lines up with the edge it belongs to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_s1_r <= '0;
      level_s2_r <= '0;
    end else begin
      level_s1_r <= analog_level;
      level_s2_r <= level_s1_r;
    end
  end

  // Control, interrupt and sample count registers
  logic shutdown_select_r;
  logic output_enable_n_r;
  logic [1:0] format_select_r;
  logic [`INT_WIDTH-1:0] int_status_r;
  logic [`INT_WIDTH-1:0] int_mask_r;
  logic [`SAMPLE_COUNT_WIDTH-1:0] sample_count_r;

  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                   (paddr == `REG_INT_STATUS) || (paddr == `REG_INT_MASK) ||
                   (paddr == `REG_LAST_RESULT) || (paddr == `REG_SAMPLE_COUNT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_select_r <= CTRL_RST[`CTRL_SHUTDOWN_BIT];
      output_enable_n_r <= CTRL_RST[`CTRL_OE_N_BIT];
      format_select_r <= CTRL_RST[`CTRL_FORMAT_MSB:`CTRL_FORMAT_LSB];
    end else if (wr_access && paddr == `REG_CTRL && pstrb[0]) begin
      shutdown_select_r <= pwdata[`CTRL_SHUTDOWN_BIT];
      output_enable_n_r <= pwdata[`CTRL_OE_N_BIT];
      format_select_r <= pwdata[`CTRL_FORMAT_MSB:`CTRL_FORMAT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_r <= `INT_MASK_RESET;
    end else if (wr_access && paddr == `REG_INT_MASK && pstrb[0]) begin
      int_mask_r <= pwdata[`INT_WIDTH-1:0];
    end
  end

  // Power state decode from the two static selects
  power_state_t state_nxt;
  always_comb begin
    case ({shutdown_select_r, output_enable_n_r})
      2'b00: state_nxt = ST_NORMAL;
      2'b01: state_nxt = ST_OUTPUT_OFF;
      2'b10: state_nxt = ST_NAP;
      2'b11: state_nxt = ST_SLEEP;
      default: state_nxt = ST_SLEEP;
    endcase
  end

  power_state_t state_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OUTPUT_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign power_state = state_r;

  // Four-level select decode
  format_t fmt;
  always_comb begin
    case (format_select_r)
      2'd0: fmt = '{twos_complement: 1'b0, stabilizer_on: 1'b0};
      2'd1: fmt = '{twos_complement: 1'b0, stabilizer_on: 1'b1};
      2'd2: fmt = '{twos_complement: 1'b1, stabilizer_on: 1'b1};
      2'd3: fmt = '{twos_complement: 1'b1, stabilizer_on: 1'b0};
      default: fmt = '{twos_complement: 1'b0, stabilizer_on: 1'b0};
    endcase
  end

  // Conversion runs only in the two awake states
  logic converting;
  logic sample_edge;
  assign converting = (state_r == ST_NORMAL) || (state_r == ST_OUTPUT_OFF);
  assign sample_edge = clk_s2_r && !clk_s3_r && converting;

  // Quantise: clamp to range, flag overflow, then code
  logic out_of_range;
  logic signed [`LEVEL_WIDTH-1:0] clamped;
  result_t fresh;
  always_comb begin
    out_of_range = (level_s2_r > LEVEL_MAX) || (level_s2_r < LEVEL_MIN);
    if (level_s2_r > LEVEL_MAX) begin
      clamped = LEVEL_MAX;
    end else if (level_s2_r < LEVEL_MIN) begin
      clamped = LEVEL_MIN;
    end else begin
      clamped = level_s2_r;
    end
    fresh.range_flag = out_of_range;
    // Offset binary is two's complement with the MSB inverted
    if (fmt.twos_complement) begin
      fresh.code = clamped[DATA_W-1:0];
    end else begin
      fresh.code = {~clamped[DATA_W-1], clamped[DATA_W-2:0]};
    end
  end

  // Pipeline: stage 0 holds the sample taken at this edge
  result_t pipe_r [LATENCY];
  result_t out_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
      out_r <= '0;
    end else if (sample_edge) begin
      pipe_r[0] <= fresh;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
      out_r <= pipe_r[LATENCY-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_count_r <= '0;
    end else if (sample_edge) begin
      sample_count_r <= sample_count_r + 1'b1;
    end
  end

  // Word and flag leave together from one register
  assign conversion_result = out_r.code;
  assign range_flag = out_r.range_flag;
  assign conversion_result_oe = (state_r == ST_NORMAL);
  assign range_flag_oe = (state_r == ST_NORMAL);

  // Sticky events; a set in the clearing cycle survives
  logic [`INT_WIDTH-1:0] int_set;
  logic [`INT_WIDTH-1:0] int_clr;
  assign int_set[`INT_RESULT_BIT] = sample_edge;
  assign int_set[`INT_RANGE_BIT] = sample_edge && pipe_r[LATENCY-1].range_flag;
  assign int_set[`INT_STATE_BIT] = (state_nxt != state_r);
  assign int_clr = (wr_access && paddr == `REG_INT_STATUS && pstrb[0]) ?
                   pwdata[`INT_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= (int_status_r & ~int_clr) | int_set;
    end
  end
  assign irq = |(int_status_r & int_mask_r);

  // Read data latched in setup, so the access phase answers at once
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: rd_mux = {28'h0, format_select_r, output_enable_n_r, shutdown_select_r};
      `REG_STATUS: rd_mux = {27'h0, converting, fmt.twos_complement,
                             fmt.stabilizer_on, state_r};
      `REG_INT_STATUS: rd_mux = {29'h0, int_status_r};
      `REG_INT_MASK: rd_mux = {29'h0, int_mask_r};
      `REG_LAST_RESULT: rd_mux = {19'h0, out_r};
      `REG_SAMPLE_COUNT: rd_mux = {16'h0, sample_count_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !addr_ok;
    end
  end
  assign pready = 1'b1;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow history of fresh results, indexed by sample number
  result_t hist_r [8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        hist_r[i] <= '0;
      end
    end else if (sample_edge) begin
      hist_r[sample_count_r[2:0]] <= fresh;
    end
  end
  logic [2:0] old_idx;
  assign old_idx = 3'(sample_count_r[2:0] - 3'(LATENCY));

  sequence edge_seen;
    clk_s2_r && !clk_s3_r;
  endsequence

  sequence counted;
    ##1 sample_count_r == $past(sample_count_r) + 1'b1;
  endsequence

  sample_start_a: assert property (edge_seen and converting |-> counted)
    else $error("sample edge did not start a conversion");

  latency_five_a: assert property (
    sample_edge && sample_count_r >= 16'(LATENCY) |=> out_r == hist_r[$past(old_idx)])
    else $error("result did not appear five samples later");

  normal_drive_a: assert property (
    !shutdown_select_r && !output_enable_n_r && $stable(output_enable_n_r)
    |=> conversion_result_oe && range_flag_oe)
    else $error("normal mode outputs not driven");

  off_convert_a: assert property (
    (state_r == ST_OUTPUT_OFF) and edge_seen |-> !conversion_result_oe and counted)
    else $error("output-off mode stopped converting or drove outputs");

  nap_hold_a: assert property (
    state_r == ST_NAP [*2] |-> $stable(out_r) && !conversion_result_oe)
    else $error("nap mode converted or drove outputs");

  sleep_state_a: assert property (
    shutdown_select_r && output_enable_n_r ##1 shutdown_select_r && output_enable_n_r
    |-> state_r == ST_SLEEP && !range_flag_oe && !conversion_result_oe)
    else $error("sleep mode not entered");

  format_code_a: assert property (
    sample_edge && !out_of_range |=>
    pipe_r[0].code == ($past(fmt.twos_complement) ? $past(level_s2_r[11:0])
                       : 12'($past(level_s2_r[11:0]) + 12'h800)))
    else $error("output coding does not match format select");

  msb_sign_a: assert property (
    sample_edge && !out_of_range && !fmt.twos_complement
    |=> pipe_r[0].code[DATA_W-1] == !$past(level_s2_r[`LEVEL_WIDTH-1]))
    else $error("top bit is not the most significant");

  range_flag_a: assert property (
    sample_edge |=> pipe_r[0].range_flag ==
    ($past(level_s2_r) > LEVEL_MAX || $past(level_s2_r) < LEVEL_MIN))
    else $error("range flag does not track input range");

  sleep_freeze_a: assert property (
    (state_r == ST_SLEEP) [*2] |-> $stable(out_r) && !range_flag_oe)
    else $error("sleep mode moved the pipeline or drove outputs");

  result_hold_a: assert property (
    !sample_edge |=> $stable(conversion_result) && $stable(range_flag))
    else $error("result changed between sample edges");

  range_event_a: assert property (
    sample_edge && pipe_r[LATENCY-1].range_flag |=> int_status_r[`INT_RANGE_BIT])
    else $error("range event not recorded");

  state_event_a: assert property (
    state_nxt != state_r |=> int_status_r[`INT_STATE_BIT] && state_r == $past(state_nxt))
    else $error("power state change not recorded");

endmodule : conv_port_ctrl

/* File: hdl/conv_port_map.svh */
`ifndef CONV_PORT_MAP_SVH
`define CONV_PORT_MAP_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INT_STATUS 12'h008
`define REG_INT_MASK 12'h00C
`define REG_LAST_RESULT 12'h010
`define REG_SAMPLE_COUNT 12'h014

// Control field positions
`define CTRL_SHUTDOWN_BIT 0
`define CTRL_OE_N_BIT 1
`define CTRL_FORMAT_LSB 2
`define CTRL_FORMAT_MSB 3

// Reset values: converting, outputs off until software enables them
`define CTRL_RESET 4'h2
`define INT_MASK_RESET 3'h0

// Interrupt status bits
`define INT_RESULT_BIT 0
`define INT_RANGE_BIT 1
`define INT_STATE_BIT 2
`define INT_WIDTH 3

// Converter figures
`define CONV_WIDTH 12
`define LEVEL_WIDTH 14
`define PIPE_LATENCY 5
`define SAMPLE_COUNT_WIDTH 16

`endif

/* File: hdl/conv_port_pkg.sv */
package conv_port_pkg;
  `include "conv_port_map.svh"

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_OUTPUT_OFF,
    ST_NAP,
    ST_SLEEP
  } power_state_t;

  typedef struct packed {
    logic range_flag;
    logic [`CONV_WIDTH-1:0] code;
  } result_t;

  typedef struct packed {
    logic twos_complement;
    logic stabilizer_on;
  } format_t;
endpackage : conv_port_pkg
